// File: src/bus_irq_defs.svh
// Register offsets, field positions and reset values of the bus interrupt flag block
`ifndef BUS_IRQ_DEFS_SVH
`define BUS_IRQ_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_W 3
`define DATA_W 16
`define OFS_BUS_CONTROL 3'h0
`define OFS_BUS_STATUS 3'h1
`define OFS_EVENT_STATUS 3'h2
`define OFS_EVENT_MASK 3'h3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_FORMAT_FIRST 0
`define CTL_FORMAT_SECOND 1
`define CTL_WAIT_INSERT 2
`define CTL_ACK_DECISION 3
`define CTL_AL_IRQ_ENABLE 4
`define CTL_STOP_IRQ_MASK 5
`define CTL_W 6
`define CTL_RESET 6'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_STOP 0
`define ST_IRQ_FLAG 1
`define ST_ACK_VALUE 2
`define ST_AL 3
`define ST_OWN_MATCH 4
`define ST_SECOND_MATCH 5
`define ST_GENERAL_CALL 6
`define ST_ERROR_STOP 7
`define ST_TX_EMPTY 8
`define ST_RX_FULL 9
`define ST_W 10

// ----------------------------------------
// Event status bits (also mask layout)
// ----------------------------------------
`define EV_START 0
`define EV_WAIT 1
`define EV_XFER_END 2
`define EV_ADDRESS 3
`define EV_ACK 4
`define EV_AL 5
`define EV_STOP 6
`define EV_BUFFER 7
`define EV_W 8
`define EV_RESET 8'h00

// ----------------------------------------
// Bit counting on the serial clock
// ----------------------------------------
`define BITS_BUS_FRAME 4'h9
`define BITS_SYNC_FRAME 4'h8
`define BIT_EIGHT 4'h8
`define BIT_SEVEN 4'h7

`endif

// File: src/bus_irq_flag_logic.sv
// Interrupt request flag logic of a two-wire serial bus interface
`timescale 1ns/1ns
`include "bus_irq_defs.svh"

module bus_irq_flag_logic
  import bus_irq_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`DATA_W-1:0] rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic master_mode,
  input wire logic transmit_mode,
  input wire logic own_address_match,
  input wire logic second_address_match,
  input wire logic general_call_match,
  input wire logic rw_received,
  input wire logic ack_one_received,
  input wire logic arbitration_lost,
  input wire logic error_stop,
  input wire logic tx_holding_to_shift,
  input wire logic shift_to_rx_holding,
  input wire logic data_write,
  input wire logic data_read,
  input wire logic transfer_controller_access,
  output logic bus_irq_req,
  output logic irq
);

  // ----------------------------------------
  // Serial line synchronisers and conditions
  // ----------------------------------------
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  // SDA moving while SCL stays high marks start or stop
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [`CTL_W-1:0] control;
  logic bus_fmt, sync_fmt, wait_insert, ack_decision_enable;
  logic arbitration_lost_irq_enable, stop_irq_mask;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= `CTL_RESET;
    end else if (wr && addr == `OFS_BUS_CONTROL) begin
      control <= wdata[`CTL_W-1:0];
    end
  end

  // Clocked serial only for first=1, second=0; every other pair is bus format
  assign sync_fmt = control[`CTL_FORMAT_FIRST] & ~control[`CTL_FORMAT_SECOND];
  assign bus_fmt = ~sync_fmt;
  assign wait_insert = control[`CTL_WAIT_INSERT];
  assign ack_decision_enable = control[`CTL_ACK_DECISION];
  assign arbitration_lost_irq_enable = control[`CTL_AL_IRQ_ENABLE];
  assign stop_irq_mask = control[`CTL_STOP_IRQ_MASK];

  // ----------------------------------------
  // Frame tracking and bit count
  // ----------------------------------------
  link_state_t link_state;
  logic [3:0] bit_cnt;
  logic rise9, rise8, fall8;
  logic lost_pending, slave_active;

  assign rise9 = bus_fmt & scl_rise & (bit_cnt == `BIT_EIGHT);
  assign rise8 = sync_fmt & scl_rise & (bit_cnt == `BIT_SEVEN);
  assign fall8 = bus_fmt & scl_fall & (bit_cnt == `BIT_EIGHT);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= 4'h0;
    end else if (start_det || stop_det) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      if ((bus_fmt && bit_cnt >= `BITS_BUS_FRAME) || (sync_fmt && bit_cnt >= `BITS_SYNC_FRAME)) begin
        bit_cnt <= 4'h1;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_state <= LINK_IDLE;
    end else if (stop_det) begin
      link_state <= LINK_IDLE;
    end else if (start_det) begin
      link_state <= LINK_FIRST_FRAME;
    end else begin
      unique case (link_state)
        LINK_IDLE: begin
          link_state <= LINK_IDLE;
        end
        LINK_FIRST_FRAME: begin
          if (rise9) begin
            link_state <= LINK_DATA_FRAME;
          end
        end
        LINK_DATA_FRAME: begin
          link_state <= LINK_DATA_FRAME;
        end
      endcase
    end
  end

  // Lost master waits for the ninth rise of the address frame, the first frame after a start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lost_pending <= 1'b0;
    end else if (arbitration_lost && master_mode) begin
      lost_pending <= 1'b1;
    end else if (rise9 && link_state == LINK_FIRST_FRAME) begin
      lost_pending <= 1'b0;
    end
  end

  // Addressed slave keeps reporting transfer ends until a new start or a stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slave_active <= 1'b0;
    end else if (start_det || stop_det) begin
      slave_active <= 1'b0;
    end else if (!master_mode && (own_address_match || second_address_match ||
                                  (general_call_match && !rw_received))) begin
      slave_active <= 1'b1;
    end
  end

  // ----------------------------------------
  // Interrupt sources
  // ----------------------------------------
  logic [`EV_W-1:0] ev;
  logic set_any, cpu_only_set, tx_start_load;

  assign tx_start_load = start_det & transmit_mode;

  always_comb begin
    ev = `EV_RESET;
    ev[`EV_START] = start_det & ((bus_fmt & master_mode) | sync_fmt);
    ev[`EV_WAIT] = fall8 & master_mode & wait_insert;
    ev[`EV_XFER_END] = (rise9 & master_mode & ~wait_insert)
                     | (rise9 & ~master_mode & slave_active)
                     | rise8;
    ev[`EV_ADDRESS] = (rise9 & lost_pending & link_state == LINK_FIRST_FRAME)
                    | (bus_fmt & ~master_mode & (own_address_match | second_address_match))
                    | (bus_fmt & ~master_mode & general_call_match & ~rw_received);
    ev[`EV_ACK] = bus_fmt & ack_decision_enable & ack_one_received;
    ev[`EV_AL] = bus_fmt & master_mode & arbitration_lost & arbitration_lost_irq_enable;
    ev[`EV_STOP] = bus_fmt & ~master_mode & ~stop_irq_mask & (stop_det | error_stop);
    ev[`EV_BUFFER] = tx_start_load | tx_holding_to_shift | shift_to_rx_holding;
  end

  assign set_any = |ev;
  // These sources need the CPU to look, so the transfer controller may not clear them
  assign cpu_only_set = ev[`EV_ACK] | ev[`EV_AL] | ev[`EV_STOP];

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic [`ST_W-1:0] status;
  logic bus_irq_flag, read_armed, cpu_only;
  logic status_wr, cpu_clear, dtc_clear;
  logic [`ST_W-1:0] sw_clear, hw_set;

  assign status_wr = wr && addr == `OFS_BUS_STATUS;
  assign cpu_clear = status_wr && !wdata[`ST_IRQ_FLAG] && read_armed;
  assign dtc_clear = transfer_controller_access && (data_read || data_write) && !cpu_only;

  always_comb begin
    sw_clear = {`ST_W{1'b0}};
    if (status_wr) begin
      sw_clear = ~wdata[`ST_W-1:0];
    end
    sw_clear[`ST_IRQ_FLAG] = 1'b0;
    sw_clear[`ST_TX_EMPTY] = data_write;
    sw_clear[`ST_RX_FULL] = data_read;
    hw_set = {`ST_W{1'b0}};
    hw_set[`ST_STOP] = stop_det;
    hw_set[`ST_ACK_VALUE] = ack_decision_enable & ack_one_received;
    hw_set[`ST_AL] = arbitration_lost & master_mode;
    hw_set[`ST_OWN_MATCH] = own_address_match;
    hw_set[`ST_SECOND_MATCH] = second_address_match;
    hw_set[`ST_GENERAL_CALL] = general_call_match & ~rw_received;
    hw_set[`ST_ERROR_STOP] = error_stop;
    hw_set[`ST_TX_EMPTY] = tx_start_load | tx_holding_to_shift;
    hw_set[`ST_RX_FULL] = shift_to_rx_holding;
  end

  // Set wins over any clear landing in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `ST_W; gi++) begin : g_status
      if (gi == `ST_IRQ_FLAG) begin : g_irq
        always_ff @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            status[gi] <= 1'b0;
          end else if (set_any) begin
            status[gi] <= 1'b1;
          end else if (cpu_clear || dtc_clear) begin
            status[gi] <= 1'b0;
          end
        end
      end else begin : g_flag
        always_ff @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            status[gi] <= 1'b0;
          end else if (hw_set[gi]) begin
            status[gi] <= 1'b1;
          end else if (sw_clear[gi]) begin
            status[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign bus_irq_flag = status[`ST_IRQ_FLAG];
  assign bus_irq_req = bus_irq_flag;

  // Reading the flag as one arms the clear; any status write disarms it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_armed <= 1'b0;
    end else if (status_wr || !bus_irq_flag) begin
      read_armed <= 1'b0;
    end else if (rd && addr == `OFS_BUS_STATUS) begin
      read_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_only <= 1'b0;
    end else if (set_any) begin
      cpu_only <= cpu_only | cpu_only_set;
    end else if (!bus_irq_flag) begin
      cpu_only <= 1'b0;
    end
  end

  // ----------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------
  logic [`EV_W-1:0] event_status, event_mask;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_status <= `EV_RESET;
    end else if (wr && addr == `OFS_EVENT_STATUS) begin
      event_status <= (event_status & ~wdata[`EV_W-1:0]) | ev;
    end else begin
      event_status <= event_status | ev;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_mask <= `EV_RESET;
    end else if (wr && addr == `OFS_EVENT_MASK) begin
      event_mask <= wdata[`EV_W-1:0];
    end
  end

  assign irq = |(event_status & event_mask);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        `OFS_BUS_CONTROL: rdata <= {{(`DATA_W-`CTL_W){1'b0}}, control};
        `OFS_BUS_STATUS: rdata <= {{(`DATA_W-`ST_W){1'b0}}, status};
        `OFS_EVENT_STATUS: rdata <= {{(`DATA_W-`EV_W){1'b0}}, event_status};
        `OFS_EVENT_MASK: rdata <= {{(`DATA_W-`EV_W){1'b0}}, event_mask};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_set_flag;
    set_any |=> bus_irq_flag;
  endproperty
  a_set_flag: assert property (p_set_flag) else $error("flag not set by event");

  property p_req_cause;
    $rose(bus_irq_req) |-> $past(set_any);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request rose without event");

  property p_wait_fall;
    (fall8 && master_mode && wait_insert) |=> bus_irq_flag && event_status[`EV_WAIT];
  endproperty
  a_wait_fall: assert property (p_wait_fall) else $error("eighth fall wait missed");

  property p_ninth_rise;
    (rise9 && master_mode && !wait_insert) |=> bus_irq_flag;
  endproperty
  a_ninth_rise: assert property (p_ninth_rise) else $error("ninth rise missed");

  property p_arb_lost;
    (bus_fmt && master_mode && arbitration_lost && arbitration_lost_irq_enable) |=> bus_irq_flag && status[`ST_AL];
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss missed");

  property p_stop;
    (bus_fmt && !master_mode && !stop_irq_mask && stop_det) |=> bus_irq_flag && status[`ST_STOP];
  endproperty
  a_stop: assert property (p_stop) else $error("slave stop missed");

  property p_write_one;
    (status_wr && wdata[`ST_IRQ_FLAG] && bus_irq_flag) |=> bus_irq_flag;
  endproperty
  a_write_one: assert property (p_write_one) else $error("write of one cleared flag");

  property p_clear_cause;
    $fell(bus_irq_flag) |-> $past(cpu_clear || dtc_clear);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("flag fell without clear");

  property p_dtc_clear;
    (dtc_clear && !set_any && bus_irq_flag) |=> !bus_irq_flag;
  endproperty
  a_dtc_clear: assert property (p_dtc_clear) else $error("controller access did not clear");

  property p_buffer;
    tx_holding_to_shift |=> status[`ST_TX_EMPTY] && bus_irq_flag;
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer move missed");

  property p_rdata_idle;
    !rd |=> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  c_start: cover property (start_det && master_mode ##[1:400] rise9);
  c_cpu_clear: cover property (bus_irq_flag ##1 cpu_clear ##1 !bus_irq_flag);
  c_slave_stop: cover property (slave_active ##[1:400] stop_det);
  c_irq: cover property ($rose(irq));

endmodule // bus_irq_flag_logic

// File: src/bus_irq_pkg.sv
// Types shared by the bus interrupt flag block
package bus_irq_pkg;
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_FIRST_FRAME,
    LINK_DATA_FRAME
  } link_state_t;
endpackage

// File: test/bus_irq_flag_logic_test.sv
// Self-checking bench for the bus interrupt flag logic
`timescale 1ns/1ns
`include "bus_irq_defs.svh"

module bus_irq_flag_logic_test;
  logic clk;
  logic reset_n;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic scl;
  logic sda;
  logic master_mode;
  logic transmit_mode;
  logic rw_received;
  logic tca;
  logic [9:0] ev_in;
  logic bus_irq_req;
  logic irq;
  logic [15:0] v;
  logic [15:0] m;
  int bad_count;
  int checks;
  int seed;
  int m_flag;

  bus_peer_model peer (.scl(scl), .sda(sda));

  bus_irq_flag_logic uut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .scl_in(scl), .sda_in(sda), .master_mode(master_mode), .transmit_mode(transmit_mode),
    .own_address_match(ev_in[0]), .second_address_match(ev_in[1]), .general_call_match(ev_in[2]),
    .rw_received(rw_received), .ack_one_received(ev_in[3]), .arbitration_lost(ev_in[4]),
    .error_stop(ev_in[5]), .tx_holding_to_shift(ev_in[6]), .shift_to_rx_holding(ev_in[7]),
    .data_write(ev_in[8]), .data_read(ev_in[9]), .transfer_controller_access(tca),
    .bus_irq_req(bus_irq_req), .irq(irq)
  );

  // ----------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------
  // Register bus and core event drivers
  // ----------------------------------------
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev_in[i] <= 1'b1;
    @(posedge clk);
    ev_in[i] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Model value against both the status bit and the request output
  task automatic chk_flag(input int e);
    logic [15:0] s;
    m_flag = e;
    rd_reg(`OFS_BUS_STATUS, s);
    chk("flag bit", {15'h0000, s[1]}, m_flag[15:0]);
    chk("irq request", {15'h0000, bus_irq_req}, m_flag[15:0]);
  endtask

  // Read arms the clear; other status bits are written with 1 so they survive
  task automatic clear_flag();
    logic [15:0] s;
    rd_reg(`OFS_BUS_STATUS, s);
    wr_reg(`OFS_BUS_STATUS, 16'hFFFD);
    m_flag = 0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    master_mode = 1'b0;
    transmit_mode = 1'b0;
    rw_received = 1'b1;
    tca = 1'b0;
    ev_in = 10'h000;
    seed = 32'hBB804A58;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd_reg(a[2:0], v);
      chk("register after reset", v, 16'h0000);
    end
    chk_flag(0);
    pulse(7);
    chk_flag(1);
    rd_reg(`OFS_BUS_STATUS, v);
    chk("rx full", v & 16'h0200, 16'h0200);
    wr_reg(`OFS_BUS_STATUS, 16'hFFFF);
    chk_flag(1);
    // The read inside the check armed the clear; a status write disarms it again
    wr_reg(`OFS_BUS_STATUS, 16'hFFFF);
    wr_reg(`OFS_BUS_STATUS, 16'hFFFD);
    chk_flag(1);
    clear_flag();
    chk_flag(0);
    transmit_mode <= 1'b1;
    pulse(6);
    chk_flag(1);
    tca <= 1'b1;
    pulse(8);
    chk_flag(0);
    pulse(7);
    chk_flag(1);
    pulse(9);
    chk_flag(0);
    rd_reg(`OFS_BUS_STATUS, v);
    chk("rx full after read", v & 16'h0200, 16'h0000);
    master_mode <= 1'b1;
    pulse(3);
    chk_flag(0);
    wr_reg(`OFS_BUS_CONTROL, 16'h0008);
    pulse(3);
    chk_flag(1);
    pulse(8);
    chk_flag(1);
    tca <= 1'b0;
    clear_flag();
    wr_reg(`OFS_BUS_CONTROL, 16'h0000);
    pulse(4);
    chk_flag(0);
    wr_reg(`OFS_BUS_CONTROL, 16'h0010);
    pulse(4);
    chk_flag(1);
    clear_flag();
    // Lost master now listens for the address frame
    master_mode <= 1'b0;
    transmit_mode <= 1'b0;
    wr_reg(`OFS_BUS_CONTROL, 16'h0000);
    peer.start_cond();
    clear_flag();
    peer.clocks(9);
    settle();
    chk_flag(1);
    clear_flag();
    peer.stop_cond();
    settle();
    chk_flag(1);
    clear_flag();
    wr_reg(`OFS_BUS_CONTROL, 16'h0020);
    pulse(5);
    chk_flag(0);
    wr_reg(`OFS_BUS_CONTROL, 16'h0008);
    pulse(5);
    chk_flag(1);
    clear_flag();
    pulse(3);
    chk_flag(1);
    clear_flag();
    // Slave: address match, frame ends, no-match frame, general call
    wr_reg(`OFS_BUS_CONTROL, 16'h0000);
    peer.start_cond();
    clear_flag();
    pulse(0);
    chk_flag(1);
    clear_flag();
    pulse(1);
    chk_flag(1);
    rd_reg(`OFS_BUS_STATUS, v);
    chk("second match", v & 16'h0020, 16'h0020);
    clear_flag();
    peer.clocks(9);
    settle();
    chk_flag(1);
    clear_flag();
    peer.stop_cond();
    peer.start_cond();
    clear_flag();
    peer.clocks(9);
    settle();
    chk_flag(0);
    rw_received <= 1'b0;
    pulse(2);
    chk_flag(1);
    clear_flag();
    peer.clocks(9);
    settle();
    chk_flag(1);
    rw_received <= 1'b1;
    peer.stop_cond();
    clear_flag();
    // Master transmit, then with wait, then clocked serial
    for (int w = 0; w < 3; w++) begin
      master_mode <= (w < 2);
      transmit_mode <= (w < 2);
      wr_reg(`OFS_BUS_CONTROL, (w == 0) ? 16'h0000 : ((w == 1) ? 16'h0004 : 16'h0001));
      peer.start_cond();
      settle();
      chk_flag(1);
      if (w < 2) begin
        rd_reg(`OFS_BUS_STATUS, v);
        chk("tx empty", v & 16'h0100, 16'h0100);
      end
      clear_flag();
      peer.clocks(7);
      settle();
      chk_flag(0);
      peer.clocks(1);
      settle();
      chk_flag((w == 0) ? 0 : 1);
      clear_flag();
      if (w < 2) begin
        peer.clocks(1);
        settle();
        chk_flag((w == 0) ? 1 : 0);
      end
      peer.stop_cond();
      clear_flag();
    end
    // Event status, mask and level interrupt
    wr_reg(`OFS_EVENT_STATUS, 16'h00FF);
    transmit_mode <= 1'b1;
    pulse(6);
    rd_reg(`OFS_EVENT_STATUS, v);
    chk("buffer event", v & 16'h0080, 16'h0080);
    for (int i = 0; i < 4; i++) begin
      m = 16'($random(seed));
      m[7] = i[0];
      wr_reg(`OFS_EVENT_MASK, m);
      #1;
      chk("irq masked", {15'h0000, irq}, {15'h0000, m[7]});
      rd_reg(`OFS_EVENT_MASK, v);
      chk("mask readback", v, m & 16'h00FF);
    end
    wr_reg(`OFS_EVENT_STATUS, 16'h0080);
    #1;
    chk("irq after clear", {15'h0000, irq}, 16'h0000);
    give_verdict();
  end
endmodule // bus_irq_flag_logic_test

// File: test/bus_peer_model.sv
// Behavioural far-side bus peer: makes start, clock pulses and stop on the two wires
`timescale 1ns/1ns

module bus_peer_model (
  output logic scl,
  output logic sda
);
  int bit_no;

  // ----------------------------------------
  // Idle bus: both lines pulled high, clock stands still between frames
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    bit_no = 0;
  end

  // Data falls while the clock is high: start
  task automatic start_cond();
    sda = 1'b0;
    #80;
    scl = 1'b0;
    #80;
  endtask

  // Data only moves while the clock is low, so no false start or stop; 160 ns a pulse
  task automatic clocks(input int n);
    repeat (n) begin
      bit_no++;
      sda = bit_no[0];
      #40;
      scl = 1'b1;
      #80;
      scl = 1'b0;
      #40;
    end
  endtask

  // Data rises while the clock is high: stop, then the pull-ups hold the bus idle
  task automatic stop_cond();
    sda = 1'b0;
    #40;
    scl = 1'b1;
    #80;
    sda = 1'b1;
    #80;
  endtask
endmodule // bus_peer_model
